// ### dv/rfs_board_model.sv
// Board model: frequency reference source and synthesizer clock
`timescale 1ns/1ps
`default_nettype none
module rfs_board_model (
   input  wire logic i_clk,
   input  wire logic i_ref_run,
   output var  logic o_freq_ref,
   output var  logic o_synth_clock
);
   logic [1:0] div_ff;
   initial
   begin
      div_ff        = 2'h0;
      o_freq_ref    = 1'b0;
      o_synth_clock = 1'b0;
   end
   // Reference stands still when stopped, as a lost source would
   always @(posedge i_clk)
   begin
      o_synth_clock <= !o_synth_clock;
      div_ff        <= div_ff + 2'h1;
      if (i_ref_run && div_ff[0])
         o_freq_ref <= !o_freq_ref;
   end
endmodule
`default_nettype wire

// ### dv/rfs_ratio_source_select_properties.sv
// Checker: port-level properties of the ratio and source select block
`timescale 1ns/1ps
`default_nettype none
module rfs_ratio_source_select_properties #(
   parameter int MISS_CYCLES      = 8,
   parameter int LOSS_WAIT_CYCLES = 32
) (
   input wire logic        i_clk,
   input wire logic        i_resetn,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic        o_pready,
   input wire logic        i_third_mode_pin,
   input wire logic        i_freq_ref_input,
   input wire logic        i_pll_locked,
   input wire logic [43:0] i_dpll_ratio,
   input wire logic        i_synth_clock,
   input wire logic [43:0] o_effective_ratio,
   input wire logic [43:0] o_fracn_value,
   input wire logic        o_fracn_dynamic,
   input wire logic        o_pll_unlocked,
   input wire logic        o_synth_clock_output,
   input wire logic        o_synth_clock_oe
);
   // ***********************************
   // Global shadow and reference gap
   // ***********************************
   logic [6:0]  glb_ff;
   logic [31:0] gap_ff;
   logic        ref_ff;
   logic        dis;
   assign dis = (glb_ff[3:1] == rfs_pkg::AUX_DIS_BOTH || glb_ff[3:1] == rfs_pkg::AUX_DIS_MAIN)
                && i_third_mode_pin;
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         glb_ff <= 7'h00;
      else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == rfs_pkg::GLOBAL_OFS)
         glb_ff <= i_pwdata[6:0];
   end
   // Own count is never shorter than the design's after the first reference edge, so a bound of MISS is safe
   always_ff @(posedge i_clk)
   begin
      ref_ff <= i_freq_ref_input;
      if (!i_resetn || i_freq_ref_input != ref_ff)
         gap_ff <= 32'h0;
      else
         gap_ff <= gap_ff + 32'h1;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // ***********************************
   // Properties
   // ***********************************
   property p_unlock_follow;
      !i_pll_locked |=> o_pll_unlocked;
   endproperty
   a_unlock_follow: assert property (p_unlock_follow) else $error("unlock not reported");
   property p_out_low;
      o_pll_unlocked && !$past(glb_ff[4]) |-> !o_synth_clock_output;
   endproperty
   a_out_low: assert property (p_out_low) else $error("output not held low");
   property p_out_pass;
      $past(i_resetn) && (!o_pll_unlocked || $past(glb_ff[4]))
         |-> o_synth_clock_output == $past(i_synth_clock);
   endproperty
   a_out_pass: assert property (p_out_pass) else $error("output not following clock");
   property p_oe_off;
      dis |=> !o_synth_clock_oe;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("driver not released");
   property p_oe_on;
      !dis |=> o_synth_clock_oe;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("driver not enabled");
   property p_dyn_value;
      o_fracn_dynamic [*3] |-> o_fracn_value == $past(i_dpll_ratio);
   endproperty
   a_dyn_value: assert property (p_dyn_value) else $error("dynamic value wrong");
   property p_static_value;
      (!o_fracn_dynamic && $stable(o_effective_ratio) && $stable(glb_ff[6:5])) [*3]
         |-> o_fracn_value == (o_effective_ratio << glb_ff[6:5]);
   endproperty
   a_static_value: assert property (p_static_value) else $error("static value wrong");
   property p_miss_gap;
      $rose(o_pll_unlocked) && $past(i_pll_locked) |-> gap_ff >= MISS_CYCLES;
   endproperty
   a_miss_gap: assert property (p_miss_gap) else $error("loss flagged too early");
endmodule
bind rfs_ratio_source_select rfs_ratio_source_select_properties #(
   .MISS_CYCLES      (MISS_CYCLES),
   .LOSS_WAIT_CYCLES (LOSS_WAIT_CYCLES)
) rfs_ratio_source_select_properties_i (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
   .i_third_mode_pin(i_third_mode_pin), .i_freq_ref_input(i_freq_ref_input),
   .i_pll_locked(i_pll_locked), .i_dpll_ratio(i_dpll_ratio), .i_synth_clock(i_synth_clock),
   .o_effective_ratio(o_effective_ratio), .o_fracn_value(o_fracn_value),
   .o_fracn_dynamic(o_fracn_dynamic), .o_pll_unlocked(o_pll_unlocked),
   .o_synth_clock_output(o_synth_clock_output), .o_synth_clock_oe(o_synth_clock_oe)
);
`default_nettype wire

// ### dv/tb_top.sv
// Testbench: ratio and source select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [31:0] R0   = 32'h0030_0000; // Below 4096, no shift loss
   localparam logic [31:0] R1   = 32'h0012_3456;
   localparam logic [43:0] DPLL = 44'h123_4567_89ab;
   logic [43:0] dpll = DPLL;
   logic        i_clk = 0, i_resetn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
   logic        i_third_mode_pin = 0, i_pll_locked = 1, ref_run = 1;
   logic [7:0]  i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0, o_prdata;
   logic [1:0]  i_mode_select_pins = 2'h0;
   logic        o_pready, o_pslverr, dyn, unlk, out, oe, freq_ref, synth_clk;
   logic [43:0] eff, fracn;
   int          fails = 0, compares = 0;
   always #12.5 i_clk = !i_clk;
   rfs_board_model rfs_board_model_i (.i_clk(i_clk), .i_ref_run(ref_run),
      .o_freq_ref(freq_ref), .o_synth_clock(synth_clk));
   rfs_ratio_source_select #(.MISS_CYCLES(8), .LOSS_WAIT_CYCLES(32)) rfs_ratio_source_select_i (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_mode_select_pins(i_mode_select_pins),
      .i_third_mode_pin(i_third_mode_pin), .i_freq_ref_input(freq_ref),
      .i_pll_locked(i_pll_locked), .i_dpll_ratio(dpll), .i_synth_clock(synth_clk),
      .o_effective_ratio(eff), .o_fracn_value(fracn), .o_fracn_dynamic(dyn),
      .o_pll_unlocked(unlk), .o_synth_clock_output(out), .o_synth_clock_oe(oe));
   // ***********************************
   // Shared tasks
   // ***********************************
   task automatic chk(input logic [43:0] s, input logic [43:0] e);
      compares++;
      if (s !== e)
      begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge i_clk);
      i_psel    <= 1'b1;
      i_pwrite  <= w;
      i_paddr   <= a;
      i_pwdata  <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do @(posedge i_clk); while (o_pready !== 1'b1);
      r = o_prdata;
      e = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
      chk(e, xe);
   endtask
   task automatic pin(input logic p);
      @(posedge i_clk);
      i_third_mode_pin <= p;
   endtask
   function automatic logic [43:0] e12(input logic [31:0] r);
      return {12'h000, r};
   endfunction
   function automatic logic [43:0] ew(input logic [31:0] r);
      return {4'h0, r, 8'h00};
   endfunction
   // ***********************************
   // Scenarios
   // ***********************************
   task automatic t_reset;
      rd(8'h00, 32'h0010_0000, 1'b0);
      rd(8'h10, 32'h0, 1'b0);
      rd(8'h20, 32'h0, 1'b0);
      rd(8'h30, 32'h0, 1'b1);
      rd(8'h05, 32'h0, 1'b1);
      chk(eff, e12(32'h0010_0000));
      chk(oe, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_ratio;
      wr(8'h00, R0);
      wr(8'h04, R1);
      wr(8'h14, 32'h4);
      @(posedge i_clk) i_mode_select_pins <= 2'h1;
      cyc(6);
      chk(eff, e12(R1));
      @(posedge i_clk) i_mode_select_pins <= 2'h0;
      cyc(6);
      chk(eff, e12(R0));
      wr(8'h20, 32'h6);
      pin(1'b1);
      for (int s = 0; s < 4; s++)
      begin
         wr(8'h10, s);
         cyc(6);
         chk(eff, e12(R0) >> (s + 1));
      end
      pin(1'b0);
      cyc(6);
      chk(eff, e12(R0));
      wr(8'h20, 32'h41);
      cyc(6);
      chk(eff, e12(R0));
      chk(fracn, e12(R0) << 2);
      rd(8'h28, 32'h00c0_0000, 1'b0);
      wr(8'h10, 32'h10);
      cyc(6);
      chk(eff, ew(R0));
      chk(fracn, DPLL);
      $display("test ratio done");
   endtask
   task automatic t_source;
      wr(8'h20, 32'hc);
      wr(8'h10, 32'h0);
      @(posedge i_clk) dpll <= ~DPLL;
      pin(1'b1);
      cyc(6);
      chk(fracn, ~DPLL);
      pin(1'b0);
      cyc(6);
      chk(dyn, 1'b0);
      chk(fracn, e12(R0));
      wr(8'h10, 32'h4);
      cyc(6);
      chk(dyn, 1'b1);
      chk(eff, e12(R1));
      $display("test source done");
   endtask
   task automatic t_loss;
      wr(8'h20, 32'h1);
      cyc(6);
      chk(eff, ew(R1));
      @(posedge i_clk) ref_run <= 1'b0;
      cyc(36);
      chk(unlk, 1'b1);
      chk(dyn, 1'b1);
      cyc(16);
      chk(dyn, 1'b0);
      chk(unlk, 1'b0);
      cyc(6);
      chk(eff, e12(R0));
      @(posedge i_clk) ref_run <= 1'b1;
      cyc(8);
      chk(eff, ew(R1));
      wr(8'h20, 32'h9);
      pin(1'b1);
      cyc(6);
      chk(dyn, 1'b0);
      pin(1'b0);
      cyc(6);
      chk(dyn, 1'b1);
      $display("test loss done");
   endtask
   task automatic t_output;
      logic a;
      wr(8'h10, 32'h0);
      wr(8'h20, 32'h0);
      @(posedge i_clk) i_pll_locked <= 1'b0;
      cyc(2);
      repeat (4)
      begin
         @(posedge i_clk);
         chk(out, 1'b0);
      end
      wr(8'h20, 32'h10);
      cyc(2);
      a = out;
      @(posedge i_clk);
      chk(out, !a);
      @(posedge i_clk) i_pll_locked <= 1'b1;
      for (int c = 0; c < 3; c++)
      begin
         wr(8'h20, c << 1);
         pin(1'b1);
         cyc(3);
         chk(oe, logic'(c == 1));
         pin(1'b0);
         cyc(3);
         chk(oe, 1'b1);
      end
      $display("test output done");
   endtask
   task automatic finish_test;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      cyc(4);
      i_resetn <= 1'b1;
      t_reset;
      t_ratio;
      t_source;
      t_loss;
      t_output;
      finish_test;
   end
   initial
   begin
      cyc(5000);
      fails++;
      finish_test;
   end
endmodule
`default_nettype wire

// ### rtl/rfs_ratio_mem.sv
// Four-slot ratio store with one bus port and one datapath read port
`timescale 1ns/1ps
`default_nettype none
module rfs_ratio_mem #(
   parameter int DATA_W = 32,
   parameter int DEPTH  = 4
) (
   input  wire logic                     i_clk,
   input  wire logic                     i_resetn,
   input  wire logic                     i_wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] i_wr_idx,
   input  wire logic [DATA_W-1:0]        i_wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] i_bus_idx,
   output logic      [DATA_W-1:0]        o_bus_data,
   input  wire logic [$clog2(DEPTH)-1:0] i_dp_idx,
   output logic      [DATA_W-1:0]        o_dp_data
);

   logic [DATA_W-1:0] slot_ff [DEPTH];

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         for (int i = 0; i < DEPTH; i++)
            slot_ff[i] <= DATA_W'(rfs_pkg::RATIO_RST);
      end
      else if (i_wr_en)
         slot_ff[i_wr_idx] <= i_wr_data;
   end

   // Registered reads; both ports see the stored value of the previous edge
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_bus_data <= '0;
         o_dp_data  <= '0;
      end
      else
      begin
         o_bus_data <= slot_ff[i_bus_idx];
         o_dp_data  <= slot_ff[i_dp_idx];
      end
   end

endmodule
`default_nettype wire

// ### rtl/rfs_ratio_source_select.sv
// Ratio selection, effective ratio and fractional-N source control
//
// Contract
// [RL1] Four ratio slots shared, mode pins select
// [RL2] Wide format: 20 integer, 12 fraction bits
// [RL3] Wide format only when set and hybrid
// [RL4] Auto mode, reference absent: 12.20 format
// [RL5] Configurer prefers 12.20 below 4096
// [RL6] Scaler scales selected ratio, pin enabled
// [RL7] Scale select: half, quarter, eighth, sixteenth
// [RL8] Effective ratio is ratio times scale
// [RL9] Reference divider compensated internally
// [RL10] Configurer avoids overflow and truncation
// [RL11] Auto switching also uses lock pointer
// [RL12] Source: static effective or dynamic PLL
// [RL13] Manual mode: lock pointer equals mode
// [RL14] Source pin function overrides source select
// [RL15] Auto: dynamic when reference present, else static
// [RL16] Wait 2^23 cycles after loss, unlocked
// [RL17] Auto active when pointer differs from mode
// [RL18] Auto active ignores source select
// [RL19] Pin can disable auto selection
// [RL20] Output tristates under pin, codes 000/010
// [RL21] Output low while unlocked unless keep set
// [RL22] Pin low enables, high disables output
// [RL23] Code 011: pin high enables scaler
// [RL24] Code 110: pin picks static or dynamic
// [RL25] Code 100: pin high disables auto
// [RL26] Timeout counter detects reference presence
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rfs_ratio_source_select #(
   parameter int MISS_CYCLES      = rfs_pkg::MISS_CYCLES,
   parameter int LOSS_WAIT_CYCLES = rfs_pkg::LOSS_WAIT_CYCLES
) (
   input  wire logic                        i_clk,
   input  wire logic                        i_resetn,
   // APB slave
   input  wire logic                        i_psel,
   input  wire logic                        i_penable,
   input  wire logic                        i_pwrite,
   input  wire logic [7:0]                  i_paddr,
   input  wire logic [31:0]                 i_pwdata,
   output logic      [31:0]                 o_prdata,
   output logic                             o_pready,
   output logic                             o_pslverr,
   // Pins and synthesizer side
   input  wire logic [1:0]                  i_mode_select_pins,
   input  wire logic                        i_third_mode_pin,
   input  wire logic                        i_freq_ref_input,
   input  wire logic                        i_pll_locked,
   input  wire logic [rfs_pkg::FRACN_W-1:0] i_dpll_ratio,
   input  wire logic                        i_synth_clock,
   output logic      [rfs_pkg::FRACN_W-1:0] o_effective_ratio,
   output logic      [rfs_pkg::FRACN_W-1:0] o_fracn_value,
   output logic                             o_fracn_dynamic,
   output logic                             o_pll_unlocked,
   output logic                             o_synth_clock_output,
   output logic                             o_synth_clock_oe
);

   localparam int FW = rfs_pkg::FRACN_W;
   localparam int CNT_W = $clog2(MISS_CYCLES + LOSS_WAIT_CYCLES + 1);
   localparam logic [CNT_W-1:0] MISS_CNT = CNT_W'(MISS_CYCLES);
   localparam logic [CNT_W-1:0] LOSS_CNT = CNT_W'(MISS_CYCLES + LOSS_WAIT_CYCLES);

   // ***********************************************************
   // Helpers
   // ***********************************************************
   function automatic logic is_aux(input logic [2:0] cfg, input logic [2:0] code);
      is_aux = (cfg == code);
   endfunction

   // Widens a slot to 24.20 form; wide format moves the binary point
   function automatic logic [FW-1:0] widen(input logic [31:0] r, input logic wide);
      if (wide)
         widen = {4'h0, r, 8'h00};
      else
         widen = {12'h000, r};
   endfunction

   // ***********************************************************
   // Register state
   // ***********************************************************
   rfs_pkg::rfs_modal_type  modal_ff [4];
   rfs_pkg::rfs_global_type glb_ff;
   rfs_pkg::rfs_ref_state_type ref_state_ff;
   rfs_pkg::rfs_ref_state_type nxt_ref_state;
   logic [CNT_W-1:0] gap_cnt_ff;
   logic             ref_prev_ff;
   logic [1:0]       slot_ff;
   logic             wide_ff;
   logic             scale_en_ff;
   logic [1:0]       scale_sel_ff;
   logic             dyn_ff;
   logic             auto_ff;
   logic [31:0]      mem_bus_data;
   logic [31:0]      mem_dp_data;

   wire logic access   = i_psel & i_penable;
   wire logic commit   = access & o_pready;
   wire logic wr_commit = commit & i_pwrite;
   wire logic ratio_hit = (i_paddr[7:4] == rfs_pkg::RATIO_BASE_OFS[7:4]) & (i_paddr[1:0] == 2'b00);
   wire logic modal_hit = (i_paddr[7:4] == rfs_pkg::MODAL_BASE_OFS[7:4]) & (i_paddr[1:0] == 2'b00);

   // ***********************************************************
   // Ratio slot store
   // ***********************************************************
   rfs_ratio_mem #(
      .DATA_W (32),
      .DEPTH  (4)
   ) u_mem (
      .i_clk      (i_clk),
      .i_resetn   (i_resetn),
      .i_wr_en    (wr_commit & ratio_hit),
      .i_wr_idx   (i_paddr[3:2]),
      .i_wr_data  (i_pwdata),
      .i_bus_idx  (i_paddr[3:2]),
      .o_bus_data (mem_bus_data),
      .i_dp_idx   (slot_ff),
      .o_dp_data  (mem_dp_data)
   );

   // ***********************************************************
   // APB slave: one wait state, data taken at the second access edge
   // ***********************************************************
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         o_pready <= 1'b0;
      else
         o_pready <= access & ~o_pready;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end
      else if (access & ~o_pready)
      begin
         o_pslverr <= 1'b0;
         if (ratio_hit)
            o_prdata <= mem_bus_data;
         else if (modal_hit)
            o_prdata <= {27'h0000000, modal_ff[i_paddr[3:2]]};
         else if (i_paddr == rfs_pkg::GLOBAL_OFS)
            o_prdata <= {25'h0000000, glb_ff};
         else if (i_paddr == rfs_pkg::STATUS_OFS)
            o_prdata <= {26'h0000000, slot_ff, o_pll_unlocked, dyn_ff, auto_ff,
                         ref_state_ff == rfs_pkg::REF_PRESENT};
         else if (i_paddr == rfs_pkg::FRACN_LO_OFS)
            o_prdata <= o_fracn_value[31:0];
         else if (i_paddr == rfs_pkg::FRACN_HI_OFS)
            o_prdata <= {20'h00000, o_fracn_value[FW-1:32]};
         else
         begin
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         for (int i = 0; i < 4; i++)
            modal_ff[i] <= rfs_pkg::MODAL_RST;
      end
      else if (wr_commit & modal_hit)
      begin
         modal_ff[i_paddr[3:2]].ratio_scale_sel      <= i_pwdata[rfs_pkg::MOD_SCALE_LSB +: 2];
         modal_ff[i_paddr[3:2]].input_lock_ratio_ptr <= i_pwdata[rfs_pkg::MOD_LOCK_LSB +: 2];
         modal_ff[i_paddr[3:2]].synth_source_sel     <= i_pwdata[rfs_pkg::MOD_SRC_BIT];
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         glb_ff <= rfs_pkg::GLOBAL_RST;
      else if (wr_commit & (i_paddr == rfs_pkg::GLOBAL_OFS))
      begin
         glb_ff.wide_integer_format_sel <= i_pwdata[rfs_pkg::GLB_WIDE_BIT];
         glb_ff.aux_pin_function_cfg    <= i_pwdata[rfs_pkg::GLB_AUX_LSB +: 3];
         glb_ff.keep_output_on_unlock   <= i_pwdata[rfs_pkg::GLB_KEEP_BIT];
         glb_ff.ref_div_log2            <= i_pwdata[rfs_pkg::GLB_DIV_LSB +: 2];
      end
   end

   // ***********************************************************
   // Reference presence: gap counter restarts on each edge
   // ***********************************************************
   wire logic ref_edge = i_freq_ref_input ^ ref_prev_ff;

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         ref_prev_ff <= 1'b0;
      else
         ref_prev_ff <= i_freq_ref_input;
   end

   // Saturates at the terminal count so a dead input stays absent
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         gap_cnt_ff <= LOSS_CNT;
      else if (ref_edge)
         gap_cnt_ff <= '0; // [RL26]
      else if (gap_cnt_ff != LOSS_CNT)
         gap_cnt_ff <= gap_cnt_ff + CNT_W'(1);
   end

   always_comb
   begin
      nxt_ref_state = ref_state_ff;
      unique case (ref_state_ff)
         rfs_pkg::REF_PRESENT:
            if (gap_cnt_ff >= MISS_CNT)
               nxt_ref_state = rfs_pkg::REF_WAITING;
         rfs_pkg::REF_WAITING:
            if (ref_edge)
               nxt_ref_state = rfs_pkg::REF_PRESENT;
            else if (gap_cnt_ff == LOSS_CNT)
               nxt_ref_state = rfs_pkg::REF_ABSENT; // [RL16] [RL26]
         rfs_pkg::REF_ABSENT:
            if (ref_edge)
               nxt_ref_state = rfs_pkg::REF_PRESENT;
         default:
            nxt_ref_state = rfs_pkg::REF_ABSENT;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         ref_state_ff <= rfs_pkg::REF_ABSENT;
      else
         ref_state_ff <= nxt_ref_state;
   end

   // ***********************************************************
   // Mode decode: slot, format, scaler and source
   // ***********************************************************
   // Waiting still counts as present, so the dynamic source is kept until timeout
   wire rfs_pkg::rfs_modal_type mcfg = modal_ff[i_mode_select_pins];
   wire logic [2:0] aux = glb_ff.aux_pin_function_cfg;
   wire logic ref_ok = (ref_state_ff != rfs_pkg::REF_ABSENT);
   wire logic auto_en = (mcfg.input_lock_ratio_ptr != i_mode_select_pins); // [RL17]
   wire logic auto_off = is_aux(aux, rfs_pkg::AUX_AUTO_DIS) & i_third_mode_pin; // [RL19] [RL25]
   wire logic auto_act = auto_en & ~auto_off;
   logic nxt_dyn;

   always_comb
   begin
      if (auto_act)
         nxt_dyn = ref_ok; // [RL15] [RL18]
      else if (is_aux(aux, rfs_pkg::AUX_SRC_SEL))
         nxt_dyn = i_third_mode_pin; // [RL14] [RL24]
      else
         nxt_dyn = mcfg.synth_source_sel; // [RL13]
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         slot_ff      <= 2'b00;
         dyn_ff       <= 1'b0;
         auto_ff      <= 1'b0;
         wide_ff      <= 1'b0;
         scale_en_ff  <= 1'b0;
         scale_sel_ff <= 2'b00;
      end
      else
      begin
         // Lock pointer slot only while auto mode runs on a live reference
         slot_ff <= (auto_act & ref_ok) ? mcfg.input_lock_ratio_ptr
                                        : i_mode_select_pins; // [RL1] [RL11]
         dyn_ff  <= nxt_dyn;
         auto_ff <= auto_act;
         // Static source always reads 12.20, which covers auto with no reference
         wide_ff <= glb_ff.wide_integer_format_sel & nxt_dyn; // [RL3] [RL4]
         scale_en_ff  <= is_aux(aux, rfs_pkg::AUX_SCALE_EN) & i_third_mode_pin; // [RL6] [RL23]
         scale_sel_ff <= mcfg.ratio_scale_sel;
      end
   end

   // ***********************************************************
   // Effective ratio and fractional-N value
   // ***********************************************************
   // Scaling truncates low bits; keeping clear of that is the configurer's job
   logic [FW-1:0] base_ratio;
   logic [FW-1:0] nxt_eff;

   always_comb
   begin
      base_ratio = widen(mem_dp_data, wide_ff); // [RL2]
      if (scale_en_ff)
         nxt_eff = base_ratio >> ({1'b0, scale_sel_ff} + 3'h1); // [RL7] [RL8]
      else
         nxt_eff = base_ratio; // [RL8]
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_effective_ratio <= '0;
         o_fracn_value     <= '0;
         o_fracn_dynamic   <= 1'b0;
      end
      else
      begin
         o_effective_ratio <= nxt_eff;
         o_fracn_dynamic   <= dyn_ff;
         if (dyn_ff)
            o_fracn_value <= i_dpll_ratio; // [RL12]
         else
            o_fracn_value <= o_effective_ratio << glb_ff.ref_div_log2; // [RL9] [RL12]
      end
   end

   // ***********************************************************
   // Lock report and clock output gating
   // ***********************************************************
   wire logic unlocked = ~i_pll_locked | (auto_act & (ref_state_ff == rfs_pkg::REF_WAITING));
   wire logic dis_fn = is_aux(aux, rfs_pkg::AUX_DIS_BOTH) | is_aux(aux, rfs_pkg::AUX_DIS_MAIN);

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_pll_unlocked       <= 1'b1;
         o_synth_clock_output <= 1'b0;
         o_synth_clock_oe     <= 1'b0;
      end
      else
      begin
         o_pll_unlocked       <= unlocked; // [RL16]
         o_synth_clock_output <= i_synth_clock & (~unlocked | glb_ff.keep_output_on_unlock); // [RL21]
         o_synth_clock_oe     <= ~(dis_fn & i_third_mode_pin); // [RL20] [RL22]
      end
   end

endmodule
`default_nettype wire

// ### shared/rfs_pkg.sv
// Package: constants, carriers and state codes of the ratio and source select block
package rfs_pkg;

   // ***********************************************************
   // Register map (byte addresses)
   // ***********************************************************
   localparam logic [7:0] RATIO_BASE_OFS  = 8'h00;
   localparam logic [7:0] MODAL_BASE_OFS  = 8'h10;
   localparam logic [7:0] GLOBAL_OFS      = 8'h20;
   localparam logic [7:0] STATUS_OFS      = 8'h24;
   localparam logic [7:0] FRACN_LO_OFS    = 8'h28;
   localparam logic [7:0] FRACN_HI_OFS    = 8'h2c;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int MOD_SCALE_LSB  = 0;
   localparam int MOD_LOCK_LSB   = 2;
   localparam int MOD_SRC_BIT    = 4;
   localparam int GLB_WIDE_BIT   = 0;
   localparam int GLB_AUX_LSB    = 1;
   localparam int GLB_KEEP_BIT   = 4;
   localparam int GLB_DIV_LSB    = 5;

   // ***********************************************************
   // Reset values and formats
   // ***********************************************************
   localparam logic [31:0] RATIO_RST      = 32'h0010_0000;
   localparam logic [4:0]  MODAL_RST      = 5'h00;
   localparam logic [6:0]  GLOBAL_RST     = 7'h00;
   localparam int          FRAC_BITS      = 20;
   localparam int          FRACN_W        = 44;
   localparam int          WIDE_SHIFT     = 8;

   // ***********************************************************
   // Timing counts, in divided timing clock cycles
   // ***********************************************************
   localparam int MISS_CYCLES = 1024;
   localparam int LOSS_WAIT_CYCLES = 2 ** 23;

   // ***********************************************************
   // Auxiliary pin function codes
   // ***********************************************************
   localparam logic [2:0] AUX_DIS_BOTH   = 3'h0;
   localparam logic [2:0] AUX_DIS_MAIN   = 3'h2;
   localparam logic [2:0] AUX_SCALE_EN   = 3'h3;
   localparam logic [2:0] AUX_AUTO_DIS   = 3'h4;
   localparam logic [2:0] AUX_SRC_SEL    = 3'h6;

   typedef struct packed {
      logic       synth_source_sel;
      logic [1:0] input_lock_ratio_ptr;
      logic [1:0] ratio_scale_sel;
   } rfs_modal_type;

   typedef struct packed {
      logic [1:0] ref_div_log2;
      logic       keep_output_on_unlock;
      logic [2:0] aux_pin_function_cfg;
      logic       wide_integer_format_sel;
   } rfs_global_type;

   typedef enum logic [1:0] {
      REF_PRESENT = 2'b00,
      REF_WAITING = 2'b01,
      REF_ABSENT  = 2'b10
   } rfs_ref_state_type;

endpackage
